// File: hdl/flash_host_pkg.sv
// Purpose: shared constants and types for the parallel flash bus host
// Assumes: mclk at 100 MHz, flash access time of the fastest speed grade
// Notes:   all pin timings are whole mclk cycles derived from ns figures
package flash_host_pkg;

  // clock and pin timing, in ns
  localparam int CLK_NS        = 10;
  localparam int T_ACC_NS      = 100;   // address/select to data valid
  localparam int T_WE_NS       = 60;    // write strobe low width
  localparam int T_RP_NS       = 500;   // hardware clear low width
  localparam int T_RH_NS       = 200;   // clear release to first access
  localparam int T_PROT_NS     = 10000; // protect/unprotect strobe width
  localparam int SYNC_STAGES   = 2;

  // least times round up to whole cycles
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC   = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC   = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_CYC = (T_PROT_NS + CLK_NS - 1) / CLK_NS;
  // strobe window for reads covers access, the input synchroniser and pin lag
  localparam int RD_CYC   = ACC_CYC + SYNC_STAGES + 2;

  // widths and field positions
  localparam int TMR_W      = 12;
  localparam int ADDR_W     = 20;
  localparam int REQ_ADDR_W = 21;
  localparam int DATA_W     = 16;
  localparam int SEL_A6     = 6;
  localparam int SEL_A1     = 1;
  localparam int SEL_A0     = 0;
  localparam int LANE_TOP   = 15;

  // protect/accelerate levels
  localparam logic [1:0] PA_LOW   = 2'h0; // outer boot sectors forced protected
  localparam logic [1:0] PA_HIGH  = 2'h1; // protection as previously set
  localparam logic [1:0] PA_ACCEL = 2'h2; // elevated level, all unprotected

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROTECT,
    OP_UNPROTECT,
    OP_RESET
  } op_t;

endpackage

// File: hdl/tmr_if.sv
// Purpose: carries the load/expire handshake between host fsm and its timer
// Assumes: single mclk domain
// Notes:   count of 1 gives the shortest interval
interface tmr_if;
  import flash_host_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             done;
  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// File: hdl/step_timer.sv
// Purpose: down counter that marks the last cycle of a loaded interval
// Assumes: count loaded is at least 1
// Notes:   done is high for one cycle, the count-th cycle after the load edge
module step_timer
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // control
  tmr_if.timer      t
);
  logic [TMR_W-1:0] left;

  // reload wins over the running count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      left <= '0;
    else if (t.load)
      left <= t.count;
    else if (left != '0)
      left <= left - 1'b1;
  end

  assign t.done = (left == {{(TMR_W-1){1'b0}}, 1'b1});

endmodule // step_timer

// File: hdl/flash_bus_host.sv
// Purpose: host that drives an asynchronous parallel flash through its pins
// Assumes: req_op/req_addr/req_wdata held stable while req_valid and not req_ready
// Notes:   every pin output comes from a flop, so pins lag the fsm by one cycle

module flash_bus_host
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // request side
  input  wire logic                  req_valid,
  input  wire flash_host_pkg::op_t   req_op,
  input  wire logic [REQ_ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0]     req_wdata,
  input  wire logic                  byte_mode,
  input  wire logic [1:0]            accel_mode,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [DATA_W-1:0]          rsp_rdata,
  // flash control pins
  output logic                       ce_n,
  output logic                       oe_n,
  output logic                       we_n,
  output logic                       clear_n,
  output logic                       id_voltage_en,
  output logic                       width_sel,
  output logic                       protect_accel_pin,
  output logic                       accel_voltage_level,
  output logic [ADDR_W-1:0]          addr_pin,
  // flash data pins, lane 15 is top_data_or_low_addr
  input  wire logic [DATA_W-1:0]     dq_in,
  output logic [DATA_W-1:0]          dq_out,
  output logic [DATA_W-1:0]          dq_oe_n
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    ST_PWR, ST_RST_LOW, ST_RST_REC, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD
  } state_t;

  state_t                  state;
  state_t                  next_state;
  op_t                     op;
  logic [REQ_ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]       wdata;
  logic                    bmode;
  logic [DATA_W-1:0]       dq_s1;
  logic [DATA_W-1:0]       dq_s2;

  tmr_if tmr ();

  step_timer u_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .t       (tmr)
  );

  function automatic logic [TMR_W-1:0] cyc(input int n);
    cyc = n[TMR_W-1:0];
  endfunction

  // decode of the latched operation
  wire is_write   = (op == OP_WRITE);
  wire is_prot    = (op == OP_PROTECT) || (op == OP_UNPROTECT);
  wire is_read    = (op == OP_READ);
  wire in_cycle   = (state == ST_SETUP) || (state == ST_STROBE) || (state == ST_HOLD);
  wire accept     = (state == ST_IDLE) && req_valid;
  wire tmr_done   = tmr.done;

  // sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_PWR:     next_state = ST_RST_LOW;
      ST_RST_LOW: if (tmr_done) next_state = ST_RST_REC;
      ST_RST_REC: if (tmr_done) next_state = ST_IDLE;
      ST_IDLE:    if (accept) next_state = (req_op == OP_RESET) ? ST_PWR : ST_SETUP;
      ST_SETUP:   next_state = ST_STROBE;
      ST_STROBE:  if (tmr_done) next_state = ST_HOLD;
      ST_HOLD:    next_state = ST_IDLE;
    endcase
  end

  // timer loads on entry to each timed state
  assign tmr.load  = (next_state != state) &&
                     ((next_state == ST_RST_LOW) || (next_state == ST_RST_REC) || (next_state == ST_STROBE));
  assign tmr.count = (next_state == ST_RST_LOW) ? cyc(RP_CYC) :
                     (next_state == ST_RST_REC) ? cyc(RH_CYC) :
                     is_read                    ? cyc(RD_CYC) :
                     is_prot                    ? cyc(PROT_CYC) : cyc(WE_CYC);

  // pin decode, registered below
  wire next_ce_n   = !in_cycle;
  wire next_oe_n   = !((state == ST_STROBE) && is_read);
  wire next_we_n   = !((state == ST_STROBE) && (is_write || is_prot));
  wire next_clear  = !((state == ST_PWR) || (state == ST_RST_LOW));
  wire next_idv    = in_cycle && is_prot;
  // byte mode shifts the word address up one bit, lane 15 carries the extra bit
  wire [ADDR_W-1:0] base_addr = bmode ? addr[ADDR_W:1] : addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] prot_addr = {base_addr[ADDR_W-1:SEL_A6+1], op == OP_UNPROTECT,
                                 base_addr[SEL_A6-1:SEL_A1+1], 1'b1, 1'b0};
  wire [ADDR_W-1:0] next_addr = is_prot ? prot_addr : base_addr;
  // data held through the hold cycle so the command latches close on it
  wire drive_data  = in_cycle && !is_read;
  wire [DATA_W-1:0] next_dq_oe_n = {
    !(bmode || (drive_data && !bmode)),
    {(LANE_TOP-8){!(drive_data && !bmode)}},
    {8{!drive_data}}};
  // byte writes go out on the low lanes whichever byte is addressed
  wire [DATA_W-1:0] next_dq_out = bmode ? {addr[0], 7'h00, wdata[7:0]} : wdata;

  // state and latched request
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_PWR;
      op    <= OP_READ;
      addr  <= '0;
      wdata <= '0;
      bmode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (accept)
      begin
        op    <= req_op;
        addr  <= req_addr;
        wdata <= req_wdata;
        bmode <= byte_mode;
      end
    end
  end

  // data pins pass two flops before any logic reads them
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // registered pins; clear held low under reset so the device restarts in reads
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ce_n                <= 1'b1;
      oe_n                <= 1'b1;
      we_n                <= 1'b1;
      clear_n             <= 1'b0;
      id_voltage_en       <= 1'b0;
      width_sel           <= 1'b0;
      protect_accel_pin   <= 1'b0;
      accel_voltage_level <= 1'b0;
      addr_pin            <= '0;
      dq_out              <= '0;
      dq_oe_n             <= '1;
    end
    else
    begin
      ce_n                <= next_ce_n;
      oe_n                <= next_oe_n;
      we_n                <= next_we_n;
      clear_n             <= next_clear;
      id_voltage_en       <= next_idv;
      width_sel           <= !bmode;
      protect_accel_pin   <= (accel_mode != PA_LOW);
      accel_voltage_level <= (accel_mode == PA_ACCEL);
      addr_pin            <= next_addr;
      dq_out              <= next_dq_out;
      dq_oe_n             <= next_dq_oe_n;
    end
  end

  // request/answer handshake; byte reads pick the low lanes only
  wire finish = (state == ST_HOLD) || ((state == ST_RST_REC) && tmr_done && op == OP_RESET);
  wire [DATA_W-1:0] rd_word = bmode ? {8'h00, dq_s2[7:0]} : dq_s2;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      req_ready <= (next_state == ST_IDLE);
      rsp_valid <= finish;
      if ((state == ST_STROBE) && tmr_done && is_read)
        rsp_rdata <= rd_word;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  read_strobes_a: assert property (!oe_n |-> !ce_n && we_n)
    else $error("output gate low without select or with write strobe");
  write_strobes_a: assert property (!we_n |-> !ce_n && oe_n)
    else $error("write strobe low with gate low or select high");
  protect_addr_a: assert property ((id_voltage_en && !we_n && !addr_pin[SEL_A6]) |->
      addr_pin[SEL_A1] && !addr_pin[SEL_A0] && clear_n)
    else $error("protect strobe with wrong low address bits");
  unprotect_addr_a: assert property ((!we_n && id_voltage_en && op == OP_UNPROTECT) |->
      addr_pin[SEL_A6] && addr_pin[SEL_A1] && !addr_pin[SEL_A0])
    else $error("unprotect strobe with wrong address bits");
  no_contention_a: assert property (!oe_n |-> dq_oe_n[LANE_TOP-1:0] == '1)
    else $error("host drives data lanes while flash outputs");
  byte_lanes_a: assert property (!width_sel && !ce_n |-> dq_oe_n[LANE_TOP-1:8] == '1 && !dq_oe_n[LANE_TOP])
    else $error("byte mode lane drive wrong");
  clear_quiet_a: assert property (!clear_n |-> ce_n && we_n && oe_n)
    else $error("access attempted while clear pin low");
  clear_width_a: assert property ($fell(clear_n) |-> !clear_n [*8])
    else $error("clear pulse too short");
  read_window_a: assert property ($fell(oe_n) |-> !oe_n [*8] ##[1:8] oe_n)
    else $error("read strobe width out of range");

endmodule // flash_bus_host

// File: test/flash_device_model.sv
// Purpose: behavioural parallel flash seen from its pins
// Assumes: a write programs directly, no command decode
// Notes:   undriven lanes show a pattern that moves each cycle
module flash_device_model
#(
  parameter int ACC_NS = 100
)
(
  // pattern clock
  input  wire logic        mclk,
  // control pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        clear_n,
  input  wire logic        id_voltage_en,
  input  wire logic        width_sel,
  input  wire logic        protect_accel_pin,
  input  wire logic        accel_voltage_level,
  input  wire logic [19:0] addr_pin,
  // data pins
  input  wire logic [15:0] dq_bus,
  output logic      [15:0] dev_dq,
  output int               bad_strobes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [7:0]  prot;
  logic [15:0] float_pat = 16'h5a5a;
  logic [15:0] rd_word;
  logic [15:0] rd_q;
  wire  [7:0]  w = addr_pin[7:0];
  wire  [2:0]  sec = addr_pin[10:8];
  wire         a_lo = dq_bus[15];
  wire         in_rst = !clear_n && !id_voltage_en;
  // elevated level wins over the low level and the sector bits
  wire         locked = !accel_voltage_level && ((!protect_accel_pin && sec >= 3'h6) || prot[sec]);
  wire         drive = !in_rst && !ce_n && !oe_n && we_n;
  initial
  begin
    prot = 8'h00;
    bad_strobes = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = {~i[7:0], i[7:0]};
  end
  // released lanes must not hold the last value
  always @(posedge mclk)
    float_pat <= ~float_pat;
  // array mode is the resting state, no command needed
  assign rd_word = width_sel ? mem[w] : {8'h00, a_lo ? mem[w][15:8] : mem[w][7:0]};
  assign #(ACC_NS) rd_q = rd_word;
  assign dev_dq[7:0] = drive ? rd_q[7:0] : float_pat[7:0];
  assign dev_dq[15:8] = (drive && width_sel) ? rd_q[15:8] : float_pat[15:8];
  // latches close on the rising write strobe
  always @(posedge we_n)
    if (!ce_n && oe_n && id_voltage_en && addr_pin[1] && !addr_pin[0])
      prot[sec] <= !addr_pin[6];
    else if (!ce_n && oe_n && !in_rst && !id_voltage_en && !locked)
      if (width_sel)
        mem[w] <= dq_bus;
      else if (a_lo)
        mem[w][15:8] <= dq_bus[7:0];
      else
        mem[w][7:0] <= dq_bus[7:0];
  // gate and write strobe low together is a host fault
  always @(negedge mclk)
    if (!ce_n && !oe_n && !we_n)
      bad_strobes <= bad_strobes + 1;
endmodule // flash_device_model

// File: test/test_flash_bus_host.sv
// Purpose: self-checking bench for the parallel flash host
// Assumes: device model answers at the pins
// Notes:   each scenario after t_reset drives requests and judges the replies
module test_flash_bus_host import flash_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset_n = 0, req_valid = 0, byte_mode = 0;
  op_t  req_op = OP_READ;
  logic [REQ_ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, dq_out, dq_oe_n, dev_dq, seen_oe, seen_dq, q;
  logic [1:0] accel_mode = PA_HIGH;
  logic req_ready, rsp_valid, ce_n, oe_n, we_n, clear_n, id_voltage_en, width_sel;
  logic protect_accel_pin, accel_voltage_level, seen_wsel, seen_id;
  logic [ADDR_W-1:0] addr_pin, seen_addr;
  wire  [DATA_W-1:0] dq_bus = (~dq_oe_n & dq_out) | (dq_oe_n & dev_dq);
  int   mismatches = 0, n_compared = 0, bad_strobes, clr_cnt = 0;
  flash_bus_host uut (.mclk, .reset_n, .req_valid, .req_op, .req_addr, .req_wdata, .byte_mode,
    .accel_mode, .req_ready, .rsp_valid, .rsp_rdata, .ce_n, .oe_n, .we_n, .clear_n, .id_voltage_en,
    .width_sel, .protect_accel_pin, .accel_voltage_level, .addr_pin, .dq_in(dq_bus), .dq_out, .dq_oe_n);
  flash_device_model #(.ACC_NS(100)) dev (.mclk, .ce_n, .oe_n, .we_n, .clear_n, .id_voltage_en,
    .width_sel, .protect_accel_pin, .accel_voltage_level, .addr_pin, .dq_bus, .dev_dq, .bad_strobes);
  initial
    forever #5 mclk = ~mclk;
  // snapshot of the pins while the write strobe is low
  always @(negedge mclk)
  begin
    if (!we_n)
    begin
      seen_oe <= dq_oe_n;
      seen_dq <= dq_out;
      seen_addr <= addr_pin;
      seen_wsel <= width_sel;
      seen_id <= id_voltage_en;
    end
    if (!clear_n)
      clr_cnt++;
  end
  function automatic logic [15:0] init(input logic [7:0] a);
    return {~a, a};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      mismatches++;
      results();
    end
  endtask
  // one request under bounded waits; read data lands in q
  task automatic op(input op_t o, input logic [20:0] a, input logic [15:0] d, input logic bm);
    int n;
    @(posedge mclk);
    #1;
    req_op = o;
    req_addr = a;
    req_wdata = d;
    byte_mode = bm;
    req_valid = 1;
    for (n = 0; n < 300 && req_ready !== 1'b1; n++)
      @(negedge mclk);
    guard(n, 300);
    @(posedge mclk);
    #1;
    req_valid = 0;
    for (n = 0; n < 1500 && rsp_valid !== 1'b1; n++)
      @(negedge mclk);
    guard(n, 1500);
    q = rsp_rdata;
  endtask
  task automatic set_accel(input logic [1:0] m);
    @(posedge mclk);
    #1;
    accel_mode = m;
  endtask
  task automatic t_reset();
    check(16'({ce_n, oe_n, we_n, clear_n, req_ready}), 16'h1c);
    check(dq_oe_n, 16'hffff);
  endtask
  task automatic t_word();
    op(OP_WRITE, 21'h00010, 16'hbeef, 0);
    check(seen_dq, 16'hbeef);
    check(16'(seen_wsel), 16'h1);
    check(seen_oe, 16'h0000);
    op(OP_READ, 21'h00010, 0, 0);
    check(q, 16'hbeef);
    op(OP_READ, 21'h00011, 0, 0);
    check(q, init(8'h11));
  endtask
  task automatic t_byte();
    op(OP_WRITE, 21'h00041, 16'h0077, 1);
    check(16'(seen_wsel), 16'h0);
    check(seen_oe, 16'h7f00);
    check(16'({seen_dq[15], seen_addr[11:0]}), 16'h1020);
    op(OP_READ, 21'h00041, 0, 1);
    check(q, 16'h0077);
    op(OP_READ, 21'h00040, 0, 1);
    check(q, 16'h0020);
  endtask
  task automatic t_prot();
    op(OP_PROTECT, 21'h00200, 0, 0);
    check(16'({seen_id, seen_addr[11:0]}), 16'h1202);
    op(OP_WRITE, 21'h00205, 16'h1234, 0);
    op(OP_READ, 21'h00205, 0, 0);
    check(q, init(8'h05));
    op(OP_UNPROTECT, 21'h00200, 0, 0);
    check(16'({seen_id, seen_addr[11:0]}), 16'h1242);
    op(OP_WRITE, 21'h00205, 16'h1234, 0);
    op(OP_READ, 21'h00205, 0, 0);
    check(q, 16'h1234);
  endtask
  task automatic t_accel();
    set_accel(PA_LOW);
    op(OP_WRITE, 21'h00706, 16'h5555, 0);
    op(OP_READ, 21'h00706, 0, 0);
    check(q, init(8'h06));
    check(16'(protect_accel_pin), 16'h0);
    set_accel(PA_ACCEL);
    op(OP_WRITE, 21'h00706, 16'h5555, 0);
    op(OP_READ, 21'h00706, 0, 0);
    check(q, 16'h5555);
    check(16'(accel_voltage_level), 16'h1);
    set_accel(PA_HIGH);
    op(OP_READ, 21'h00706, 0, 0);
    check(16'({protect_accel_pin, accel_voltage_level}), 16'h2);
  endtask
  task automatic t_clear();
    clr_cnt = 0;
    op(OP_RESET, 0, 0, 0);
    // the pass through the power-up state adds one cycle ahead of the timed low phase
    check(16'(clr_cnt), 16'(RP_CYC + 1));
    op(OP_READ, 21'h00010, 0, 0);
    check(q, 16'hbeef);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    t_reset();
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1;
    t_word();
    t_byte();
    t_prot();
    t_accel();
    t_clear();
    check(16'(bad_strobes), 16'h0);
    results();
  end
endmodule // test_flash_bus_host
